/* File: hdl/pfpr_defs.vh */
// Purpose: constants for the pin function and power register bank
// Assumes: control port delivers whole-register writes and reads, addressed by word
// Notes: included by the bank and its pin decoder
// Overview of operation
// (R1) two 24-bit pin function registers hold twelve 4-bit pin codes
// (R2) low register holds pins 0-5, high pins 6-11, ascending nibbles
// (R3) top bit of a pin code inverts the pin signal both ways, except 1111 on adc-mapped pins, which is not inverted
// (R4) pull-up on whenever the pin is a gpio or serial input
// (R5) 0000 debounced input, 0001 plain input, 0010 output, 0011 open collector
// (R6) codes 1000 to 1011 are the same functions with inversion
// (R7) 0100 serial port, 1100 serial port inverted
// (R8) 1111 routes pin to aux adc, only on adc-mapped pins
// (R9) host may write reserved codes, such as 1111 on pins without an adc channel; device treats them as debounced input
// (R10) bits 9:8 of power register select aux adc smoothing mode
// (R11) power bits: 7 adcs, 6 ref buffer, 5 reference, 3:0 dacs
// (R12) bit 15 of aux adc enable register switches the aux adc on
// (R13) bit 2 of oscillator register stops the oscillator when set
// (R14) host writes 01 to dac init field to initialize the dacs
// (R15) registers decode at 0x0820, 0x0821, 0x0822, 0x0824, 0x0826, 0x0827
// (R16) every register resets to zero
// (R17) reserved bits read zero and ignore writes
`ifndef PFPR_DEFS_VH
`define PFPR_DEFS_VH
`define PFPR_ADDR_W 16
`define PFPR_DATA_W 24
`define PFPR_ADDR_PIN_LOW 16'h0820
`define PFPR_ADDR_PIN_HIGH 16'h0821
`define PFPR_ADDR_POWER 16'h0822
`define PFPR_ADDR_AUX_EN 16'h0824
`define PFPR_ADDR_OSC 16'h0826
`define PFPR_ADDR_DAC 16'h0827
`define PFPR_PINS_PER_REG 6
`define PFPR_NUM_PINS 12
`define PFPR_CODE_W 4
`define PFPR_PIN_REG_RESET 24'h000000
`define PFPR_REG16_RESET 16'h0000
`define PFPR_POWER_MASK 16'h03EF
`define PFPR_AUX_EN_BIT 15
`define PFPR_OSC_BIT 2
`define PFPR_SMOOTH_LO 8
`define PFPR_SMOOTH_HI 9
`define PFPR_ADC_PD_BIT 7
`define PFPR_REFBUF_PD_BIT 6
`define PFPR_REF_PD_BIT 5
`define PFPR_DAC_PD_HI 3
`define PFPR_DAC_PD_LO 0
`define PFPR_DAC0_PD_BIT 3
`define PFPR_DAC1_PD_BIT 2
`define PFPR_DAC2_PD_BIT 1
`define PFPR_DAC3_PD_BIT 0
`define PFPR_PINS_ALL 12'hFFF
`define PFPR_PINS_NONE 12'h000
`define PFPR_DAC_INIT_HI 1
`define PFPR_DAC_INIT_LO 0
`define PFPR_INV_BIT 3
`define PFPR_CODE_IN_DEB 3'h0
`define PFPR_CODE_IN_RAW 3'h1
`define PFPR_CODE_OUT 3'h2
`define PFPR_CODE_OC 3'h3
`define PFPR_CODE_SERIAL 3'h4
`define PFPR_CODE_AUX 4'hF
`define PFPR_AUX_PIN_MASK 12'h30C
`endif

/* File: hdl/pfpr_pin_decode.v */
// Purpose: decode one pin's 4-bit function code into control levels
// Assumes: code is a registered value
// Notes: purely combinational
`timescale 1ns/1ps
`include "pfpr_defs.vh"
module pfpr_pin_decode #(
    parameter AUX_CAPABLE = 0
) (
    input wire [3:0] i_code,
    output wire o_debounce,
    output wire o_gpio_in,
    output wire o_gpio_out,
    output wire o_open_coll,
    output wire o_serial,
    output wire o_aux,
    output wire o_invert,
    output wire o_pullup
);
    wire [2:0] base;
    wire aux_hit;
    assign base = i_code[2:0];
    // aux code only valid where the pin reaches an adc channel
    assign aux_hit = (i_code == `PFPR_CODE_AUX) && (AUX_CAPABLE != 0); // R8
    assign o_aux = aux_hit; // R8
    assign o_invert = i_code[`PFPR_INV_BIT] & ~aux_hit; // R3 R6
    assign o_gpio_out = (base == `PFPR_CODE_OUT); // R5 R6
    assign o_open_coll = (base == `PFPR_CODE_OC); // R5 R6
    assign o_serial = (base == `PFPR_CODE_SERIAL); // R7
    // reserved codes fall back to debounced input
    assign o_gpio_in = ~aux_hit & ~o_gpio_out & ~o_open_coll & ~o_serial; // R9
    assign o_debounce = o_gpio_in & (base != `PFPR_CODE_IN_RAW); // R5 R9
    assign o_pullup = o_gpio_in | o_serial; // R4
endmodule // pfpr_pin_decode

/* File: hdl/pfpr_bank.v */
// Purpose: pin function and power control register bank
// Assumes: i_wr_en / i_rd_en are single-cycle strobes synchronous to i_clk
// Notes: read data registered, valid one cycle after i_rd_en
`timescale 1ns/1ps
`include "pfpr_defs.vh"
module pfpr_bank #(
    parameter NUM_PINS = `PFPR_NUM_PINS,
    parameter [11:0] AUX_PIN_MASK = `PFPR_AUX_PIN_MASK
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire [15:0] i_addr,
    input wire i_wr_en,
    input wire [23:0] i_wr_data,
    input wire i_rd_en,
    output reg [23:0] o_rd_data,
    output reg o_rd_valid,
    output reg [11:0] o_pin_invert,
    output reg [11:0] o_pin_pullup,
    output reg [11:0] o_pin_debounce,
    output reg [11:0] o_pin_gpio_in,
    output reg [11:0] o_pin_gpio_out,
    output reg [11:0] o_pin_open_coll,
    output reg [11:0] o_pin_serial,
    output reg [11:0] o_pin_aux,
    output reg [1:0] o_aux_smoothing_select,
    output reg o_adc_powerdown,
    output reg o_ref_buffer_powerdown,
    output reg o_reference_powerdown,
    output reg [3:0] o_dac_powerdown,
    output reg o_aux_adc_on,
    output reg o_osc_powerdown,
    output reg [1:0] o_dac_init_field
);
    // ****************************************
    // registers
    // ****************************************
    reg [23:0] pin_function_low_r;
    reg [23:0] pin_function_high_r;
    reg [15:0] power_r;
    reg aux_on_r;
    reg osc_pd_r;
    reg [1:0] dac_init_r;
    reg [23:0] rd_nxt;
    wire [47:0] codes;
    wire [11:0] dec_inv, dec_pu, dec_deb, dec_in, dec_out, dec_oc, dec_ser, dec_aux;

    function hit;
        input [15:0] a;
        input [15:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            pin_function_low_r <= `PFPR_PIN_REG_RESET; // R16
            pin_function_high_r <= `PFPR_PIN_REG_RESET; // R16
            power_r <= `PFPR_REG16_RESET; // R16
            aux_on_r <= 1'b0; // R16
            osc_pd_r <= 1'b0; // R16
            dac_init_r <= 2'h0; // R16
        end else if (i_wr_en) begin
            if (hit(i_addr, `PFPR_ADDR_PIN_LOW)) begin // R15
                pin_function_low_r <= i_wr_data; // R1 R2
            end
            if (hit(i_addr, `PFPR_ADDR_PIN_HIGH)) begin // R15
                pin_function_high_r <= i_wr_data; // R1 R2
            end
            if (hit(i_addr, `PFPR_ADDR_POWER)) begin // R15
                // bit 4 and upper bits are reserved
                power_r <= i_wr_data[15:0] & `PFPR_POWER_MASK; // R10 R11 R17
            end
            if (hit(i_addr, `PFPR_ADDR_AUX_EN)) begin // R15
                aux_on_r <= i_wr_data[`PFPR_AUX_EN_BIT]; // R12 R17
            end
            if (hit(i_addr, `PFPR_ADDR_OSC)) begin // R15
                osc_pd_r <= i_wr_data[`PFPR_OSC_BIT]; // R13 R17
            end
            if (hit(i_addr, `PFPR_ADDR_DAC)) begin // R15
                // stored as written; 01 is the only meaningful value
                dac_init_r <= i_wr_data[`PFPR_DAC_INIT_HI:`PFPR_DAC_INIT_LO]; // R14 R17
            end
        end
    end

    // ****************************************
    // read back
    // ****************************************
    always @* begin
        rd_nxt = 24'h000000;
        case (i_addr)
            `PFPR_ADDR_PIN_LOW: rd_nxt = pin_function_low_r;
            `PFPR_ADDR_PIN_HIGH: rd_nxt = pin_function_high_r;
            `PFPR_ADDR_POWER: rd_nxt = {8'h00, power_r}; // R17
            `PFPR_ADDR_AUX_EN: rd_nxt = {8'h00, aux_on_r, 15'h0000}; // R17
            `PFPR_ADDR_OSC: rd_nxt = {21'h000000, osc_pd_r, 2'h0}; // R17
            `PFPR_ADDR_DAC: rd_nxt = {22'h000000, dac_init_r}; // R17
            default: rd_nxt = 24'h000000;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rd_data <= 24'h000000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            // unmapped addresses read zero
            o_rd_data <= i_rd_en ? rd_nxt : 24'h000000;
        end
    end

    // ****************************************
    // pin decode
    // ****************************************
    assign codes = {pin_function_high_r, pin_function_low_r}; // R2

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            pfpr_pin_decode #(
                .AUX_CAPABLE(AUX_PIN_MASK[g])
            ) u_dec (
                .i_code(codes[g*`PFPR_CODE_W +: `PFPR_CODE_W]), // R1 R2
                .o_debounce(dec_deb[g]),
                .o_gpio_in(dec_in[g]),
                .o_gpio_out(dec_out[g]),
                .o_open_coll(dec_oc[g]),
                .o_serial(dec_ser[g]),
                .o_aux(dec_aux[g]),
                .o_invert(dec_inv[g]),
                .o_pullup(dec_pu[g])
            );
        end
    endgenerate

    // ****************************************
    // registered outputs
    // ****************************************
    // one cycle of latency keeps every output straight from a flop
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            // zero codes mean debounced input with pull-up on every pin
            o_pin_invert <= `PFPR_PINS_NONE; // R16
            o_pin_pullup <= `PFPR_PINS_ALL; // R16
            o_pin_debounce <= `PFPR_PINS_ALL; // R16
            o_pin_gpio_in <= `PFPR_PINS_ALL; // R16
            o_pin_gpio_out <= `PFPR_PINS_NONE; // R16
            o_pin_open_coll <= `PFPR_PINS_NONE; // R16
            o_pin_serial <= `PFPR_PINS_NONE; // R16
            o_pin_aux <= `PFPR_PINS_NONE; // R16
            o_aux_smoothing_select <= 2'h0;
            o_adc_powerdown <= 1'b0;
            o_ref_buffer_powerdown <= 1'b0;
            o_reference_powerdown <= 1'b0;
            o_dac_powerdown <= 4'h0;
            o_aux_adc_on <= 1'b0;
            o_osc_powerdown <= 1'b0;
            o_dac_init_field <= 2'h0;
        end else begin
            o_pin_invert <= dec_inv; // R3
            o_pin_pullup <= dec_pu; // R4
            o_pin_debounce <= dec_deb; // R5
            o_pin_gpio_in <= dec_in; // R5
            o_pin_gpio_out <= dec_out; // R5
            o_pin_open_coll <= dec_oc; // R5
            o_pin_serial <= dec_ser; // R7
            o_pin_aux <= dec_aux; // R8
            o_aux_smoothing_select <= power_r[`PFPR_SMOOTH_HI:`PFPR_SMOOTH_LO]; // R10
            o_adc_powerdown <= power_r[`PFPR_ADC_PD_BIT]; // R11
            o_ref_buffer_powerdown <= power_r[`PFPR_REFBUF_PD_BIT]; // R11
            o_reference_powerdown <= power_r[`PFPR_REF_PD_BIT]; // R11
            // bit 3 is dac0 .. bit 0 is dac3; o_dac_powerdown[k] is dac k
            o_dac_powerdown <= {power_r[`PFPR_DAC3_PD_BIT], power_r[`PFPR_DAC2_PD_BIT],
                power_r[`PFPR_DAC1_PD_BIT], power_r[`PFPR_DAC0_PD_BIT]}; // R11
            o_aux_adc_on <= aux_on_r; // R12
            o_osc_powerdown <= osc_pd_r; // R13
            o_dac_init_field <= dac_init_r; // R14
        end
    end
endmodule // pfpr_bank

/* File: tb/pfpr_host.sv */
// Purpose: host model writing and reading the bank
// Assumes: strobes one cycle long, driven 1 ns after the edge
// Notes: idle bus shows inverted last values, never stale ones
`timescale 1ns/1ps
module pfpr_host (
    input wire i_clk,
    input wire [23:0] i_rd_data,
    input wire i_rd_valid,
    output logic [15:0] o_addr = 16'h0000,
    output logic o_wr_en = 1'b0,
    output logic [23:0] o_wr_data = 24'h000000,
    output logic o_rd_en = 1'b0
);
    // callers may hand in reserved pin codes, such as 1111 on pins without an adc channel
    task automatic wr(input logic [15:0] a, input logic [23:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wr_data = d;
        o_wr_en = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr_en = 1'b0;
        o_wr_data = ~d;
        o_addr = ~a;
    endtask
    // answer is due one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [23:0] d, output logic ok);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd_en = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd_en = 1'b0;
        o_addr = ~a;
        ok = i_rd_valid;
        d = i_rd_data;
    endtask
endmodule // pfpr_host

/* File: tb/pfpr_bank_assertions.sv */
// Purpose: port checks for the bank
// Assumes: one clock, sync reset
// Notes: bound into every bank instance
`timescale 1ns/1ps
module pfpr_chk #(
    parameter [11:0] AUX_PIN_MASK = 12'h30C
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire [15:0] i_addr,
    input wire i_wr_en,
    input wire [23:0] i_wr_data,
    input wire i_rd_en,
    input wire [23:0] o_rd_data,
    input wire o_rd_valid,
    input wire [11:0] o_pin_invert,
    input wire [11:0] o_pin_pullup,
    input wire [11:0] o_pin_gpio_in,
    input wire [11:0] o_pin_aux,
    input wire [11:0] o_pin_serial,
    input wire o_adc_powerdown,
    input wire o_osc_powerdown
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire mapped = i_addr[15:3] == 13'h0104 && i_addr[2:0] != 3'h3 && i_addr[2:0] != 3'h5;
    sequence s_wr(a);
        i_wr_en && i_addr == a;
    endsequence
    a_rd_valid_next: assert property (i_rd_en |=> o_rd_valid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!i_rd_en |=> !o_rd_valid)
        else $error("valid without read");
    a_unmapped_zero: assert property (i_rd_en && !mapped |=> o_rd_data == 24'h0)
        else $error("unmapped read not zero");
    a_power_rsvd_zero: assert property (i_rd_en && i_addr == 16'h0822 |=> (o_rd_data & ~24'h0003EF) == 24'h0)
        else $error("reserved power bits read set");
    a_adc_pd_write: assert property (s_wr(16'h0822) |-> ##2 o_adc_powerdown == $past(i_wr_data[7], 2))
        else $error("adc powerdown not from write");
    a_osc_pd_write: assert property (s_wr(16'h0826) |-> ##2 o_osc_powerdown == $past(i_wr_data[2], 2))
        else $error("osc powerdown not from write");
    a_input_pullup: assert property (o_pin_pullup == (o_pin_gpio_in | o_pin_serial))
        else $error("input pin without pull-up");
    a_aux_capable: assert property ((o_pin_aux & ~AUX_PIN_MASK) == 12'h000)
        else $error("aux on pin without channel");
    a_hold_no_write: assert property (!i_wr_en |-> ##2 $stable(o_adc_powerdown) && $stable(o_pin_invert))
        else $error("control changed without write");
endmodule // pfpr_chk
bind pfpr_bank pfpr_chk #(.AUX_PIN_MASK(AUX_PIN_MASK)) pfpr_chk_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_pin_invert(o_pin_invert), .o_pin_pullup(o_pin_pullup), .o_pin_gpio_in(o_pin_gpio_in),
    .o_pin_aux(o_pin_aux), .o_pin_serial(o_pin_serial), .o_adc_powerdown(o_adc_powerdown),
    .o_osc_powerdown(o_osc_powerdown));

/* File: tb/test_pin_function_and_power_regs.sv */
// Purpose: self-checking bench for the bank
// Assumes: outputs settle one edge after the write is taken
// Notes: expectations built from the code table
`timescale 1ns/1ps
module test_pin_function_and_power_regs;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    wire [15:0] ad;
    wire we, re, rv, ap, bp, rp, ae, op;
    wire [23:0] wd, rdd;
    wire [11:0] inv, pu, deb, gi, go, oc, ser, aux;
    wire [1:0] sm, di;
    wire [3:0] dp;
    int bad_count = 0;
    int n_compared = 0;
    logic [11:0] e;
    always #5 i_clk = ~i_clk;
    pfpr_host pfpr_host_i (.i_clk(i_clk), .i_rd_data(rdd), .i_rd_valid(rv), .o_addr(ad),
        .o_wr_en(we), .o_wr_data(wd), .o_rd_en(re));
    pfpr_bank pfpr_bank_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(ad), .i_wr_en(we),
        .i_wr_data(wd), .i_rd_en(re), .o_rd_data(rdd), .o_rd_valid(rv), .o_pin_invert(inv),
        .o_pin_pullup(pu), .o_pin_debounce(deb), .o_pin_gpio_in(gi), .o_pin_gpio_out(go),
        .o_pin_open_coll(oc), .o_pin_serial(ser), .o_pin_aux(aux), .o_aux_smoothing_select(sm),
        .o_adc_powerdown(ap), .o_ref_buffer_powerdown(bp), .o_reference_powerdown(rp),
        .o_dac_powerdown(dp), .o_aux_adc_on(ae), .o_osc_powerdown(op), .o_dac_init_field(di));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrs(input logic [15:0] a, input logic [23:0] d);
        pfpr_host_i.wr(a, d);
        @(posedge i_clk);
        #1;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [23:0] x);
        logic [23:0] d;
        logic ok;
        pfpr_host_i.rd(a, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk({8'h00, d}, {8'h00, x});
    endtask
    task automatic t_codes;
        logic [3:0] c [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
        foreach (c[i]) begin
            pfpr_host_i.wr(16'h0820, {6{c[i]}});
            wrs(16'h0821, {6{c[i]}});
            e = (c[i] == 4'hF) ? 12'hCF3 : 12'hFFF;
            chk(inv, c[i][3] ? e : 12'h0);
            chk(go, c[i][2:0] == 3'h2 ? 12'hFFF : 12'h0);
            chk(oc, c[i][2:0] == 3'h3 ? 12'hFFF : 12'h0);
            chk(ser, c[i][2:0] == 3'h4 ? 12'hFFF : 12'h0);
            chk(aux, c[i] == 4'hF ? 12'h30C : 12'h0);
            chk(deb, c[i][2:0] == 3'h0 ? 12'hFFF : (c[i] == 4'hF ? 12'hCF3 : 12'h0));
            chk(gi & pu, gi);
            chk(gi, (c[i][2:1] == 2'h0 || c[i] == 4'hF) ? e : 12'h0);
            chk(pu, (c[i][2:1] == 2'h0 || c[i][2:0] == 3'h4 || c[i] == 4'hF) ? e : 12'h0);
            rdchk(16'h0820, {6{c[i]}});
            rdchk(16'h0821, {6{c[i]}});
        end
    endtask
    task automatic t_power;
        wrs(16'h0822, 24'hFFFFFF);
        rdchk(16'h0822, 24'h0003EF);
        chk({ap, bp, rp, dp}, 7'h7F);
        for (int k = 0; k < 4; k++) begin
            wrs(16'h0822, {14'h0, k[1:0], 8'h08});
            chk({sm, ap, dp}, {k[1:0], 5'h01});
        end
        wrs(16'h0822, 24'h000040);
        chk({ap, bp, rp, dp}, 7'h20);
    endtask
    task automatic t_misc;
        pfpr_host_i.wr(16'h0820, 24'h200000);
        wrs(16'h0821, 24'h300002);
        chk({go, oc}, 24'h060800);
        wrs(16'h0824, 24'hFFFFFF);
        rdchk(16'h0824, 24'h008000);
        wrs(16'h0826, 24'hFFFFFF);
        rdchk(16'h0826, 24'h000004);
        chk({ae, op}, 2'h3);
        wrs(16'h0827, 24'h000001);
        rdchk(16'h0827, 24'h000001);
        chk(di, 2'h1);
        wrs(16'h0823, 24'hFFFFFF);
        rdchk(16'h0823, 24'h0);
        rdchk(16'h0822, 24'h000040);
        rdchk(16'h0825, 24'h0);
    endtask
    task automatic t_reset;
        logic [15:0] a [6] = '{16'h0820, 16'h0821, 16'h0822, 16'h0824, 16'h0826, 16'h0827};
        foreach (a[i]) rdchk(a[i], 24'h0);
        chk({gi, deb}, 24'hFFFFFF);
        chk({pu, go}, 24'hFFF000);
        chk({aux, inv}, 24'h000000);
        chk({oc, ser}, 24'h000000);
        chk({sm, ap, bp, rp, dp, ae, op, di}, 13'h0);
    endtask
    task automatic wrap_up;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        t_reset();
        t_codes();
        t_power();
        t_misc();
        @(posedge i_clk);
        #1 i_reset_n = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        t_reset();
        wrap_up();
    end
endmodule // test_pin_function_and_power_regs
